// ### rtl/ffcm_pkg.sv
// package: address map, field positions, reset values and carriers for the coefficient bank
package ffcm_pkg;

    localparam logic [7:0] FFCM_ADDR_PROBE_CFG  = 8'h1F;
    localparam logic [7:0] FFCM_ADDR_GAIN_LO    = 8'h80;
    localparam logic [7:0] FFCM_ADDR_GAIN_HI    = 8'h9F;
    localparam logic [7:0] FFCM_ADDR_F1_LO      = 8'hA0;
    localparam logic [7:0] FFCM_ADDR_F1_HI      = 8'hB5;
    localparam logic [7:0] FFCM_ADDR_F2_LO      = 8'hB6;
    localparam logic [7:0] FFCM_ADDR_F2_HI      = 8'hF5;
    localparam logic [7:0] FFCM_ADDR_F1_SEL     = 8'hF6;
    localparam logic [7:0] FFCM_ADDR_F2_SEL     = 8'hF7;

    localparam int FFCM_BIT_PROBE_EN    = 0;
    localparam int FFCM_BIT_TAP_LSB     = 1;
    localparam int FFCM_BIT_DITHER_ENABLE_CHAN_A      = 6;
    localparam int FFCM_BIT_DITHER_ENABLE_CHAN_B      = 7;
    localparam int FFCM_BIT_SEL_CHAN_A  = 0;
    localparam int FFCM_BIT_SEL_CHAN_B  = 1;
    localparam int FFCM_BIT_HOST_PAGE   = 2;

    localparam logic [7:0] FFCM_RST_PROBE_CFG = 8'hC0;
    localparam logic [7:0] FFCM_RST_BYTE      = 8'h00;
    localparam logic [2:0] FFCM_RST_SEL       = 3'h0;

    localparam int FFCM_GAIN_DEPTH = 32;
    localparam int FFCM_F1_BYTES   = 22;
    localparam int FFCM_F2_BYTES   = 64;
    localparam int FFCM_F1_TAPS    = 11;
    localparam int FFCM_F2_TAPS    = 32;
    localparam int FFCM_TAP_W      = 20;
    localparam int FFCM_OSC_W      = 17;
    localparam int FFCM_MIX_W      = 15;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ffcm_host_req_t;

    typedef struct packed {
        logic [FFCM_TAP_W-1:0] fir_out_bi;
        logic [FFCM_TAP_W-1:0] fir_out_bq;
        logic [FFCM_TAP_W-1:0] fir_out_ai;
        logic [FFCM_TAP_W-1:0] fir_out_aq;
        logic [FFCM_TAP_W-1:0] fir_in_bi;
        logic [FFCM_TAP_W-1:0] fir_in_bq;
        logic [FFCM_TAP_W-1:0] fir_in_ai;
        logic [FFCM_TAP_W-1:0] fir_in_aq;
        logic [FFCM_OSC_W-1:0] osc_a_cos;
        logic [FFCM_OSC_W-1:0] osc_a_sin;
        logic [FFCM_OSC_W-1:0] osc_b_cos;
        logic [FFCM_OSC_W-1:0] osc_b_sin;
        logic [FFCM_MIX_W-1:0] mix_ai;
        logic [FFCM_MIX_W-1:0] mix_aq;
        logic [FFCM_MIX_W-1:0] mix_bi;
        logic [FFCM_MIX_W-1:0] mix_bq;
    } ffcm_probe_nodes_t;

    // which memory each filter of each channel reads: 0 = memory A, 1 = memory B
    typedef struct packed {
        logic f1_chan_a;
        logic f1_chan_b;
        logic f2_chan_a;
        logic f2_chan_b;
    } ffcm_mem_sel_t;

endpackage

// ### rtl/ffcm_byte_mem.sv
// byte-wide flip-flop storage with host write port and two read ports
`timescale 1ns/1ps
module ffcm_byte_mem
    import ffcm_pkg::*;
#(
    parameter int DEPTH = 32
)
(
    input  wire logic                     clock,
    input  wire logic                     rstn,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [7:0]               wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [7:0]               rd_data,
    output logic      [DEPTH*8-1:0]       all_q
);

    localparam int IDX_W = $clog2(DEPTH);

    logic [7:0] mem_q [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_byte
            always_ff @(posedge clock)
            begin
                if (!rstn)
                    mem_q[g] <= FFCM_RST_BYTE;
                else if (wr_en && (wr_idx == IDX_W'(g)))
                    mem_q[g] <= wr_data;
            end
            assign all_q[g*8 +: 8] = mem_q[g];
        end
    endgenerate

    assign rd_data = mem_q[rd_idx];

endmodule // ffcm_byte_mem

// ### rtl/ffcm_probe_mux.sv
// probe tap selection with low-bit zero fill for narrow nodes
`timescale 1ns/1ps
module ffcm_probe_mux
    import ffcm_pkg::*;
(
    input  wire logic [4:0]             tap_sel,
    input  wire ffcm_probe_nodes_t      nodes,
    output logic      [FFCM_TAP_W-1:0]  tap_value
);

    localparam int OSC_PAD = FFCM_TAP_W - FFCM_OSC_W;
    localparam int MIX_PAD = FFCM_TAP_W - FFCM_MIX_W;

    always_comb
    begin
        unique case (tap_sel[3:0])
            4'h0: tap_value = nodes.fir_out_bi;
            4'h1: tap_value = nodes.fir_out_bq;
            4'h2: tap_value = nodes.fir_out_ai;
            4'h3: tap_value = nodes.fir_out_aq;
            4'h4: tap_value = nodes.fir_in_bi;
            4'h5: tap_value = nodes.fir_in_bq;
            4'h6: tap_value = nodes.fir_in_ai;
            4'h7: tap_value = nodes.fir_in_aq;
            4'h8: tap_value = {nodes.osc_a_cos, {OSC_PAD{1'b0}}};
            4'h9: tap_value = {nodes.osc_a_sin, {OSC_PAD{1'b0}}};
            4'hA: tap_value = {nodes.osc_b_cos, {OSC_PAD{1'b0}}};
            4'hB: tap_value = {nodes.osc_b_sin, {OSC_PAD{1'b0}}};
            4'hC: tap_value = {nodes.mix_ai, {MIX_PAD{1'b0}}};
            4'hD: tap_value = {nodes.mix_aq, {MIX_PAD{1'b0}}};
            4'hE: tap_value = {nodes.mix_bi, {MIX_PAD{1'b0}}};
            default: tap_value = {nodes.mix_bq, {MIX_PAD{1'b0}}};
        endcase
    end

endmodule // ffcm_probe_mux

// ### rtl/ffcm_regs.sv
// host register bank: probe control, dither, gain loop RAM, two coefficient memories
//
// Summary of operation
// - probe codes 0-7 route 20-bit filter taps
// - codes 8-11 show oscillator outputs, 3 LSBs zero
// - codes 12-15 show mixer outputs, 5 LSBs zero
// - probe byte bit 6 enables channel A dither
// - probe byte bit 7 enables channel B dither
// - 32-byte shared gain loop RAM at 128-159
// - eleven first-filter coefficients, low byte first
// - thirty-two second-filter coefficients, low byte first
// - first-filter host page picks memory B/A
// - second-filter host page picks memory B/A
// - 246 bit 0 selects channel A first-filter memory
// - 246 bit 1 selects channel B first-filter memory
// - 247 bit 0 selects channel A second-filter memory
// - 31 bit 0 enables probe point access
// - 247 bit 1 selects channel B second-filter memory
`timescale 1ns/1ps
module ffcm_regs
    import ffcm_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        rstn,
    input  wire ffcm_host_req_t              host_req,
    output logic      [7:0]                  host_rdata,
    input  wire ffcm_probe_nodes_t           probe_nodes,
    output logic      [FFCM_TAP_W-1:0]       probe_out,
    output logic                             probe_valid,
    output logic                             dither_enable_chan_a,
    output logic                             dither_enable_chan_b,
    output ffcm_mem_sel_t                    mem_sel,
    output logic      [FFCM_GAIN_DEPTH*8-1:0] gain_loop_params,
    output logic      [FFCM_F1_TAPS*16-1:0]  f1_coef_mem_a,
    output logic      [FFCM_F1_TAPS*16-1:0]  f1_coef_mem_b,
    output logic      [FFCM_F2_TAPS*16-1:0]  f2_coef_mem_a,
    output logic      [FFCM_F2_TAPS*16-1:0]  f2_coef_mem_b
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    logic       hit_gain;
    logic       hit_f1;
    logic       hit_f2;
    logic [4:0] gain_idx;
    logic [4:0] f1_idx;
    logic [5:0] f2_idx;

    assign hit_gain = in_range(host_req.addr, FFCM_ADDR_GAIN_LO, FFCM_ADDR_GAIN_HI);
    assign hit_f1   = in_range(host_req.addr, FFCM_ADDR_F1_LO, FFCM_ADDR_F1_HI);
    assign hit_f2   = in_range(host_req.addr, FFCM_ADDR_F2_LO, FFCM_ADDR_F2_HI);
    assign gain_idx = 5'(host_req.addr - FFCM_ADDR_GAIN_LO);
    assign f1_idx   = 5'(host_req.addr - FFCM_ADDR_F1_LO);
    assign f2_idx   = 6'(host_req.addr - FFCM_ADDR_F2_LO);

    ////////////////////////////////////////////////////////////////////////
    // control registers

    logic [7:0] probe_cfg_q;
    logic [2:0] f1_sel_q;
    logic [2:0] f2_sel_q;

    always_ff @(posedge clock)
    begin
        if (!rstn)
            probe_cfg_q <= FFCM_RST_PROBE_CFG;
        else if (host_req.wr && host_req.addr == FFCM_ADDR_PROBE_CFG)
            probe_cfg_q <= host_req.wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
            f1_sel_q <= FFCM_RST_SEL;
        else if (host_req.wr && host_req.addr == FFCM_ADDR_F1_SEL)
            f1_sel_q <= host_req.wdata[2:0];
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
            f2_sel_q <= FFCM_RST_SEL;
        else if (host_req.wr && host_req.addr == FFCM_ADDR_F2_SEL)
            f2_sel_q <= host_req.wdata[2:0];
    end

    logic f1_page;
    logic f2_page;
    assign f1_page = f1_sel_q[FFCM_BIT_HOST_PAGE];
    assign f2_page = f2_sel_q[FFCM_BIT_HOST_PAGE];

    ////////////////////////////////////////////////////////////////////////
    // storage

    logic [7:0] gain_rd;
    logic [7:0] f1a_rd;
    logic [7:0] f1b_rd;
    logic [7:0] f2a_rd;
    logic [7:0] f2b_rd;
    logic [FFCM_GAIN_DEPTH*8-1:0] gain_all;
    logic [FFCM_F1_BYTES*8-1:0]   f1a_all;
    logic [FFCM_F1_BYTES*8-1:0]   f1b_all;
    logic [FFCM_F2_BYTES*8-1:0]   f2a_all;
    logic [FFCM_F2_BYTES*8-1:0]   f2b_all;

    ffcm_byte_mem #(.DEPTH(FFCM_GAIN_DEPTH)) u_gain (
        .clock   (clock),
        .rstn    (rstn),
        .wr_en   (host_req.wr && hit_gain),
        .wr_idx  (gain_idx),
        .wr_data (host_req.wdata),
        .rd_idx  (gain_idx),
        .rd_data (gain_rd),
        .all_q   (gain_all)
    );

    ffcm_byte_mem #(.DEPTH(FFCM_F1_BYTES)) u_f1a (
        .clock   (clock),
        .rstn    (rstn),
        .wr_en   (host_req.wr && hit_f1 && !f1_page),
        .wr_idx  (f1_idx),
        .wr_data (host_req.wdata),
        .rd_idx  (f1_idx),
        .rd_data (f1a_rd),
        .all_q   (f1a_all)
    );

    ffcm_byte_mem #(.DEPTH(FFCM_F1_BYTES)) u_f1b (
        .clock   (clock),
        .rstn    (rstn),
        .wr_en   (host_req.wr && hit_f1 && f1_page),
        .wr_idx  (f1_idx),
        .wr_data (host_req.wdata),
        .rd_idx  (f1_idx),
        .rd_data (f1b_rd),
        .all_q   (f1b_all)
    );

    ffcm_byte_mem #(.DEPTH(FFCM_F2_BYTES)) u_f2a (
        .clock   (clock),
        .rstn    (rstn),
        .wr_en   (host_req.wr && hit_f2 && !f2_page),
        .wr_idx  (f2_idx),
        .wr_data (host_req.wdata),
        .rd_idx  (f2_idx),
        .rd_data (f2a_rd),
        .all_q   (f2a_all)
    );

    ffcm_byte_mem #(.DEPTH(FFCM_F2_BYTES)) u_f2b (
        .clock   (clock),
        .rstn    (rstn),
        .wr_en   (host_req.wr && hit_f2 && f2_page),
        .wr_idx  (f2_idx),
        .wr_data (host_req.wdata),
        .rd_idx  (f2_idx),
        .rd_data (f2b_rd),
        .all_q   (f2b_all)
    );

    ////////////////////////////////////////////////////////////////////////
    // host read-back, registered

    logic [7:0] rdata_d;

    always_comb
    begin
        rdata_d = 8'h00;
        if (host_req.addr == FFCM_ADDR_PROBE_CFG)
            rdata_d = probe_cfg_q;
        else if (host_req.addr == FFCM_ADDR_F1_SEL)
            rdata_d = {5'h00, f1_sel_q};
        else if (host_req.addr == FFCM_ADDR_F2_SEL)
            rdata_d = {5'h00, f2_sel_q};
        else if (hit_gain)
            rdata_d = gain_rd;
        else if (hit_f1)
            rdata_d = f1_page ? f1b_rd : f1a_rd;
        else if (hit_f2)
            rdata_d = f2_page ? f2b_rd : f2a_rd;
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
            host_rdata <= 8'h00;
        else if (host_req.rd)
            host_rdata <= rdata_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs to the datapath, all from flip-flops

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            dither_enable_chan_a <= FFCM_RST_PROBE_CFG[FFCM_BIT_DITHER_ENABLE_CHAN_A];
            dither_enable_chan_b <= FFCM_RST_PROBE_CFG[FFCM_BIT_DITHER_ENABLE_CHAN_B];
            mem_sel              <= '0;
        end
        else
        begin
            dither_enable_chan_a <= probe_cfg_q[FFCM_BIT_DITHER_ENABLE_CHAN_A];
            dither_enable_chan_b <= probe_cfg_q[FFCM_BIT_DITHER_ENABLE_CHAN_B];
            // independent bits, so both channels may pick the same memory
            mem_sel.f1_chan_a    <= f1_sel_q[FFCM_BIT_SEL_CHAN_A];
            mem_sel.f1_chan_b    <= f1_sel_q[FFCM_BIT_SEL_CHAN_B];
            mem_sel.f2_chan_a    <= f2_sel_q[FFCM_BIT_SEL_CHAN_A];
            mem_sel.f2_chan_b    <= f2_sel_q[FFCM_BIT_SEL_CHAN_B];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            gain_loop_params <= '0;
            f1_coef_mem_a    <= '0;
            f1_coef_mem_b    <= '0;
            f2_coef_mem_a    <= '0;
            f2_coef_mem_b    <= '0;
        end
        else
        begin
            // byte image is already low-byte-first per coefficient
            gain_loop_params <= gain_all;
            f1_coef_mem_a    <= f1a_all;
            f1_coef_mem_b    <= f1b_all;
            f2_coef_mem_a    <= f2a_all;
            f2_coef_mem_b    <= f2b_all;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // probe point

    logic [FFCM_TAP_W-1:0] tap_value;

    ffcm_probe_mux u_probe (
        .tap_sel   (probe_cfg_q[FFCM_BIT_TAP_LSB +: 5]),
        .nodes     (probe_nodes),
        .tap_value (tap_value)
    );

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            probe_out   <= '0;
            probe_valid <= 1'b0;
        end
        else
        begin
            probe_valid <= probe_cfg_q[FFCM_BIT_PROBE_EN];
            probe_out   <= probe_cfg_q[FFCM_BIT_PROBE_EN] ? tap_value : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    chk_dither_a_follows: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && host_req.addr == FFCM_ADDR_PROBE_CFG
        |=> ##1 dither_enable_chan_a == $past(host_req.wdata[FFCM_BIT_DITHER_ENABLE_CHAN_A], 2))
        else $error("dither A not following write");

    chk_dither_b_follows: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && host_req.addr == FFCM_ADDR_PROBE_CFG
        |=> ##1 dither_enable_chan_b == $past(host_req.wdata[FFCM_BIT_DITHER_ENABLE_CHAN_B], 2))
        else $error("dither B not following write");

    chk_probe_gated: assert property (@(posedge clock) disable iff (!rstn)
        !probe_valid |-> probe_out == '0)
        else $error("probe output without enable");

    chk_osc_low_zero: assert property (@(posedge clock) disable iff (!rstn)
        probe_valid && $past(probe_cfg_q[4:1]) inside {[4'h8:4'hB]}
        |-> probe_out[2:0] == 3'h0)
        else $error("oscillator tap low bits not zero");

    chk_mix_low_zero: assert property (@(posedge clock) disable iff (!rstn)
        probe_valid && $past(probe_cfg_q[4:1]) inside {[4'hC:4'hF]}
        |-> probe_out[4:0] == 5'h00)
        else $error("mixer tap low bits not zero");

    chk_f1a_sel: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && host_req.addr == FFCM_ADDR_F1_SEL
        |=> ##1 mem_sel.f1_chan_a == $past(host_req.wdata[0], 2))
        else $error("channel A first-filter select wrong");

    chk_f1b_sel: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && host_req.addr == FFCM_ADDR_F1_SEL
        |=> ##1 mem_sel.f1_chan_b == $past(host_req.wdata[1], 2))
        else $error("channel B first-filter select wrong");

    chk_f2a_sel: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && host_req.addr == FFCM_ADDR_F2_SEL
        |=> ##1 mem_sel.f2_chan_a == $past(host_req.wdata[0], 2))
        else $error("channel A second-filter select wrong");

    chk_probe_valid: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && host_req.addr == FFCM_ADDR_PROBE_CFG
        |=> ##1 probe_valid == $past(host_req.wdata[FFCM_BIT_PROBE_EN], 2))
        else $error("probe enable not following write");

    chk_fir_tap_route: assert property (@(posedge clock) disable iff (!rstn)
        probe_valid && $past(probe_cfg_q[4:1]) == 4'h0
        |-> probe_out == $past(probe_nodes.fir_out_bi))
        else $error("filter tap not routed to probe");

    chk_f2b_sel: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && host_req.addr == FFCM_ADDR_F2_SEL
        |=> ##1 mem_sel.f2_chan_b == $past(host_req.wdata[1], 2))
        else $error("channel B second-filter select wrong");

    chk_f1_page_write: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && hit_f1 && f1_page |=> $stable(f1a_all))
        else $error("page B write reached memory A");

    chk_f2_page_write: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && hit_f2 && !f2_page |=> $stable(f2b_all))
        else $error("page A write reached memory B");

    chk_gain_readback: assert property (@(posedge clock) disable iff (!rstn)
        host_req.wr && hit_gain ##1 host_req.rd && $past(host_req.addr) == host_req.addr
        |=> host_rdata == $past(host_req.wdata, 2))
        else $error("gain RAM read-back mismatch");

    cov_probe_osc: cover property (@(posedge clock) disable iff (!rstn)
        probe_valid && probe_cfg_q[4:1] == 4'h9);
    cov_shared_mem: cover property (@(posedge clock) disable iff (!rstn)
        mem_sel.f1_chan_a && mem_sel.f1_chan_b && !f1_page && host_req.wr && hit_f1);
    cov_f2_page_b: cover property (@(posedge clock) disable iff (!rstn)
        host_req.wr && hit_f2 && f2_page);
    cov_probe_mix: cover property (@(posedge clock) disable iff (!rstn)
        probe_valid && probe_cfg_q[4:1] == 4'hE);

endmodule // ffcm_regs

// ### test/ffcm_regs_tb.sv
// self-checking bench for the coefficient and control register bank
`timescale 1ns/1ps
module testbench
    import ffcm_pkg::*;
;
    logic              clock;
    logic              rstn;
    ffcm_host_req_t    host_req;
    logic [7:0]        host_rdata;
    ffcm_probe_nodes_t probe_nodes;
    logic [19:0]       probe_out;
    logic              probe_valid;
    logic              dither_enable_chan_a;
    logic              dither_enable_chan_b;
    ffcm_mem_sel_t     mem_sel;
    logic [255:0]      gain_loop_params;
    logic [175:0]      f1_coef_mem_a;
    logic [175:0]      f1_coef_mem_b;
    logic [511:0]      f2_coef_mem_a;
    logic [511:0]      f2_coef_mem_b;
    int                err_total;
    int                checks_done;
    int                seed;
    logic [7:0]        m_gain [32];
    logic [7:0]        m_f1 [2][22];
    logic [7:0]        m_f2 [2][64];
    logic [7:0]        m31;
    logic [7:0]        m246;
    logic [7:0]        m247;

    ffcm_regs i_dut (
        .clock                (clock),
        .rstn                 (rstn),
        .host_req             (host_req),
        .host_rdata           (host_rdata),
        .probe_nodes          (probe_nodes),
        .probe_out            (probe_out),
        .probe_valid          (probe_valid),
        .dither_enable_chan_a (dither_enable_chan_a),
        .dither_enable_chan_b (dither_enable_chan_b),
        .mem_sel              (mem_sel),
        .gain_loop_params     (gain_loop_params),
        .f1_coef_mem_a        (f1_coef_mem_a),
        .f1_coef_mem_b        (f1_coef_mem_b),
        .f2_coef_mem_a        (f2_coef_mem_a),
        .f2_coef_mem_b        (f2_coef_mem_b)
    );

    always #12.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        if (err_total == 0 && checks_done > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic model_reset;
        m31 = FFCM_RST_PROBE_CFG;
        m246 = 8'h00;
        m247 = 8'h00;
        foreach (m_gain[i]) m_gain[i] = 8'h00;
        foreach (m_f1[p, i]) m_f1[p][i] = 8'h00;
        foreach (m_f2[p, i]) m_f2[p][i] = 8'h00;
    endtask

    task automatic model_wr(input logic [7:0] a, input logic [7:0] d);
        if (a == FFCM_ADDR_PROBE_CFG) m31 = d;
        else if (a >= FFCM_ADDR_GAIN_LO && a <= FFCM_ADDR_GAIN_HI) m_gain[a - 8'h80] = d;
        else if (a >= FFCM_ADDR_F1_LO && a <= FFCM_ADDR_F1_HI) m_f1[m246[2]][a - 8'hA0] = d;
        else if (a >= FFCM_ADDR_F2_LO && a <= FFCM_ADDR_F2_HI) m_f2[m247[2]][a - 8'hB6] = d;
        else if (a == FFCM_ADDR_F1_SEL) m246 = {5'h00, d[2:0]};
        else if (a == FFCM_ADDR_F2_SEL) m247 = {5'h00, d[2:0]};
    endtask

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a == FFCM_ADDR_PROBE_CFG) return m31;
        if (a >= FFCM_ADDR_GAIN_LO && a <= FFCM_ADDR_GAIN_HI) return m_gain[a - 8'h80];
        if (a >= FFCM_ADDR_F1_LO && a <= FFCM_ADDR_F1_HI) return m_f1[m246[2]][a - 8'hA0];
        if (a >= FFCM_ADDR_F2_LO && a <= FFCM_ADDR_F2_HI) return m_f2[m247[2]][a - 8'hB6];
        if (a == FFCM_ADDR_F1_SEL) return m246;
        if (a == FFCM_ADDR_F2_SEL) return m247;
        return 8'h00;
    endfunction

    function automatic logic [19:0] exp_probe(input logic [3:0] c, input ffcm_probe_nodes_t n);
        case (c)
            4'h0: return n.fir_out_bi;
            4'h1: return n.fir_out_bq;
            4'h2: return n.fir_out_ai;
            4'h3: return n.fir_out_aq;
            4'h4: return n.fir_in_bi;
            4'h5: return n.fir_in_bq;
            4'h6: return n.fir_in_ai;
            4'h7: return n.fir_in_aq;
            4'h8: return {n.osc_a_cos, 3'h0};
            4'h9: return {n.osc_a_sin, 3'h0};
            4'hA: return {n.osc_b_cos, 3'h0};
            4'hB: return {n.osc_b_sin, 3'h0};
            4'hC: return {n.mix_ai, 5'h00};
            4'hD: return {n.mix_aq, 5'h00};
            4'hE: return {n.mix_bi, 5'h00};
            default: return {n.mix_bq, 5'h00};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // writes leave the strobe up so back-to-back requests need no release
    task automatic host_write(input logic [7:0] a, input logic [7:0] d);
        host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        model_wr(a, d);
        @(posedge clock);
    endtask

    task automatic host_read(input logic [7:0] a);
        host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        host_req <= '0;
        @(posedge clock);
        chk("host_rdata", {12'h000, exp_rd(a)}, {12'h000, host_rdata});
    endtask

    task automatic settle;
        host_req <= '0;
        repeat (3) @(posedge clock);
    endtask

    task automatic fill(input logic [7:0] lo, input int n);
        for (int i = 0; i < n; i++) host_write(lo + 8'(i), 8'($random(seed)));
    endtask

    task automatic verify(input logic [7:0] lo, input int n);
        for (int i = 0; i < n; i++) host_read(lo + 8'(i));
    endtask

    task automatic check_outs;
        for (int i = 0; i < 32; i++) chk("gain_loop_params", 20'(m_gain[i]), 20'(gain_loop_params[8*i+:8]));
        for (int i = 0; i < 22; i++)
        begin
            chk("f1_coef_mem_a", 20'(m_f1[0][i]), 20'(f1_coef_mem_a[8*i+:8]));
            chk("f1_coef_mem_b", 20'(m_f1[1][i]), 20'(f1_coef_mem_b[8*i+:8]));
        end
        for (int i = 0; i < 64; i++)
        begin
            chk("f2_coef_mem_a", 20'(m_f2[0][i]), 20'(f2_coef_mem_a[8*i+:8]));
            chk("f2_coef_mem_b", 20'(m_f2[1][i]), 20'(f2_coef_mem_b[8*i+:8]));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        results;
    end

    initial
    begin
        logic [287:0] nodes_raw;
        logic [7:0]   r;
        clock = 1'b0;
        rstn = 1'b0;
        host_req = '0;
        probe_nodes = '0;
        err_total = 0;
        checks_done = 0;
        seed = 32'hdbc7a462;
        model_reset();
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chk("dither_enable_chan_a", 20'h00001, 20'(dither_enable_chan_a));
        chk("dither_enable_chan_b", 20'h00001, 20'(dither_enable_chan_b));
        host_read(FFCM_ADDR_PROBE_CFG);
        // probe codes with random node values and dither bits
        for (int c = 0; c < 17; c++)
        begin
            for (int w = 0; w < 9; w++) nodes_raw[32*w+:32] = $random(seed);
            probe_nodes <= ffcm_probe_nodes_t'(nodes_raw);
            r = 8'($random(seed));
            host_write(FFCM_ADDR_PROBE_CFG, {r[7:6], 1'b0, 4'(c), c < 16});
            settle();
            chk("probe_valid", 20'(m31[0]), 20'(probe_valid));
            chk("probe_out", m31[0] ? exp_probe(4'(c), probe_nodes) : 20'h00000, probe_out);
            chk("dither_enable_chan_a", 20'(m31[6]), 20'(dither_enable_chan_a));
            chk("dither_enable_chan_b", 20'(m31[7]), 20'(dither_enable_chan_b));
        end
        host_read(FFCM_ADDR_PROBE_CFG);
        // both pages of both windows, then the shared gain table
        host_write(FFCM_ADDR_F1_SEL, 8'h00);
        host_write(FFCM_ADDR_F2_SEL, 8'h00);
        fill(FFCM_ADDR_GAIN_LO, 32);
        fill(FFCM_ADDR_F1_LO, 22);
        fill(FFCM_ADDR_F2_LO, 64);
        host_write(FFCM_ADDR_F1_SEL, 8'h04);
        host_write(FFCM_ADDR_F2_SEL, 8'hFC);
        fill(FFCM_ADDR_F1_LO, 22);
        fill(FFCM_ADDR_F2_LO, 64);
        verify(FFCM_ADDR_F1_LO, 22);
        verify(FFCM_ADDR_F2_LO, 64);
        host_write(FFCM_ADDR_F1_SEL, 8'h00);
        host_write(FFCM_ADDR_F2_SEL, 8'h00);
        verify(FFCM_ADDR_F1_LO, 22);
        verify(FFCM_ADDR_F2_LO, 64);
        verify(FFCM_ADDR_GAIN_LO, 32);
        settle();
        check_outs();
        // every memory choice per filter and channel, shared choices included
        for (int k = 0; k < 16; k++)
        begin
            r = 8'($random(seed));
            host_write(FFCM_ADDR_F1_SEL, {r[7:2], 2'(k)});
            host_read(FFCM_ADDR_F1_SEL);
            host_write(FFCM_ADDR_F2_SEL, {r[5:0], 2'(k >> 2)});
            host_read(FFCM_ADDR_F2_SEL);
            settle();
            chk("mem_sel", 20'({k[0], k[1], k[2], k[3]}), 20'(mem_sel));
            chk("f1_chan_a", 20'(k[0]), 20'(mem_sel.f1_chan_a));
            chk("f1_chan_b", 20'(k[1]), 20'(mem_sel.f1_chan_b));
            chk("f2_chan_a", 20'(k[2]), 20'(mem_sel.f2_chan_a));
            chk("f2_chan_b", 20'(k[3]), 20'(mem_sel.f2_chan_b));
        end
        // both channels on memory B while memory A is rewritten; read right after write
        host_write(FFCM_ADDR_F1_SEL, 8'h03);
        settle();
        host_write(FFCM_ADDR_F1_LO, 8'($random(seed)));
        host_write(FFCM_ADDR_GAIN_LO + 8'h05, 8'($random(seed)));
        host_read(FFCM_ADDR_GAIN_LO + 8'h05);
        host_read(FFCM_ADDR_F1_LO);
        settle();
        check_outs();
        // unmapped places take no write and read back zero
        host_write(8'h20, 8'h5A);
        host_write(8'hFF, 8'hA5);
        host_read(8'h20);
        host_read(8'hFF);
        host_read(8'h00);
        // second reset in mid-run restores defaults
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        model_reset();
        @(posedge clock);
        host_read(FFCM_ADDR_PROBE_CFG);
        settle();
        check_outs();
        chk("mem_sel", 20'h00000, 20'(mem_sel));
        chk("dither_enable_chan_a", 20'h00001, 20'(dither_enable_chan_a));
        chk("dither_enable_chan_b", 20'h00001, 20'(dither_enable_chan_b));
        chk("probe_valid", 20'h00000, 20'(probe_valid));
        results();
    end
endmodule // testbench
